// [logic/gpio_exp_pkg.sv]
// constants, register map and link states of the gpio expander target
// assumes one 8-bit port, a 7-bit bus address and byte-wide registers
package gpio_exp_pkg;

  // register pointer values
  localparam logic [4:0] REG_ID_CTRL  = 5'h01;
  localparam logic [4:0] REG_DIR      = 5'h03;
  localparam logic [4:0] REG_OUT      = 5'h05;
  localparam logic [4:0] REG_HIZ      = 5'h07;
  localparam logic [4:0] REG_DFLT     = 5'h09;
  localparam logic [4:0] REG_PULL_EN  = 5'h0B;
  localparam logic [4:0] REG_PULL_SEL = 5'h0D;
  localparam logic [4:0] REG_IN_LEVEL = 5'h0F;
  localparam logic [4:0] REG_IRQ_MASK = 5'h11;
  localparam logic [4:0] REG_IRQ_STAT = 5'h13;
  localparam logic [4:0] PTR_STEP     = 5'h02;

  // reset values
  localparam logic [7:0] RST_DIR      = 8'h00;
  localparam logic [7:0] RST_OUT      = 8'h00;
  localparam logic [7:0] RST_HIZ      = 8'hFF;
  localparam logic [7:0] RST_DFLT     = 8'h00;
  localparam logic [7:0] RST_PULL_EN  = 8'hFF;
  localparam logic [7:0] RST_PULL_SEL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [4:0] RST_POINTER  = 5'h01;

  // id register fields; both codes are arbitrary
  localparam logic [2:0] MAKER_CODE    = 3'h5;
  localparam logic [2:0] REVISION_CODE = 3'h1;
  localparam int         SW_RESET_BIT  = 0;

  // command byte fields
  localparam int         CMD_AUTO_BIT  = 7;

  // bus addresses without the direction bit
  localparam logic [6:0] ADDR_STRAP_LO = 7'h43;
  localparam logic [6:0] ADDR_STRAP_HI = 7'h44;

  // serial framing
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  typedef enum logic [2:0] {
    ST_ADDR = 3'b000,
    ST_AACK = 3'b001,
    ST_CMD  = 3'b011,
    ST_WACK = 3'b010,
    ST_WR   = 3'b110,
    ST_RD   = 3'b111,
    ST_RACK = 3'b101,
    ST_IDLE = 3'b100
  } link_state_t;

endpackage : gpio_exp_pkg

// [logic/gpio_exp_regs.sv]
// i2c target, register map and port pin control of an 8-bit expander
// assumes scl is the link clock, all pins arrive unsynchronised
//
// Function
// - sda falling while scl high is a start and restarts byte reception
// - address byte arrives msb first, ending with the direction bit
// - matching address is acknowledged by holding sda low on ninth pulse
// - one bit per scl pulse; sda change during scl high is start/stop
// - sda rising while scl high is a stop
// - bytes are eight bits plus acknowledge; transmitter releases sda
// - every byte received while addressed is acknowledged
// - master nack on last read byte makes the target release sda
// - address 86h/87h with strap low, 88h/89h with strap high
// - direction bit 1 reads from target, 0 writes to it
// - first written byte after address is stored as register pointer
// - reads use the pointer left by the latest command byte
// - command bit 7 set steps the pointer after each written byte and each read byte the master acknowledges
// - command bit 7 clear keeps all bytes on one register
// - writes to read-only registers leave them unchanged
// - auto stepping walks odd pointers 01h to 13h in order
// - every reset loads register defaults
// - input pin has both output drivers off
// - output pin with its hiz bit clear drives its output level, input buffer off
// - pull-down on at power-up, then pull bits steer switches
// - writing 1 to id bit 0 resets registers, not the link; reads 0
// - reading interrupt status clears it and releases the interrupt
// - direction bit 1 makes an output, 0 an input
// - input level reads 1 for output pins; writes ignored
`timescale 1ns/1ps
module gpio_exp_regs (
  // system
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // bus link
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap,
  // interrupt pin, open drain
  output logic            irq_out,
  output logic            irq_oe,
  // port pins
  input  wire logic [7:0] port_pin_in,
  output logic      [7:0] port_pin_out,
  output logic      [7:0] port_pin_oe,
  output logic      [7:0] high_side_driver,
  output logic      [7:0] low_side_driver,
  output logic      [7:0] pullup_switch,
  output logic      [7:0] pulldown_switch,
  output logic      [7:0] input_buffer_en
);
  import gpio_exp_pkg::*;

  // ---------------- link domain (scl) ----------------
  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  tx_sh;
  logic        frame_clr;
  logic        link_rst_n;
  logic        strap_m, strap_s;
  logic [4:0]  pointer;
  logic        pointer_auto_step;
  logic [7:0]  pin_direction, output_level, output_hiz;
  logic [7:0]  input_compare_default, pull_enable, pull_select, irq_mask;
  logic        sw_rst_tog, clr_irq_tog, clr_rst_tog;
  logic [16:0] back_m, back_s;
  logic [7:0]  rx_byte;
  logic [7:0]  rd_val;
  logic [6:0]  own_addr;
  logic        wr_done, rd_done, rd_more;
  logic [7:0]  in_level, irq_status;
  logic        rst_flag;

  assign link_rst_n = resetn & ~frame_clr;
  assign rx_byte    = {shift[6:0], sda_in};
  assign own_addr   = strap_s ? ADDR_STRAP_HI : ADDR_STRAP_LO;
  assign wr_done    = (state == ST_CMD || state == ST_WR) &&
                      bit_cnt == LAST_DATA_BIT;
  assign rd_done    = (state == ST_RD) && bit_cnt == LAST_DATA_BIT;
  assign rd_more    = (state == ST_RACK) && !sda_in;
  assign sda_out    = 1'b0;
  assign irq_out    = 1'b0;

  function automatic logic [4:0] step_ptr(input logic [4:0] p);
    if (p >= REG_IRQ_STAT)
      step_ptr = REG_ID_CTRL;
    else
      step_ptr = p + PTR_STEP;
  endfunction : step_ptr

  // strap sampled on the link clock, stable through the frame
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      strap_m <= 1'b0;
      strap_s <= 1'b0;
    end else begin
      strap_m <= addr_strap;
      strap_s <= strap_m;
    end
  end

  // ref-domain status brought over for reads
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      back_m <= 17'h00000;
      back_s <= 17'h00000;
    end else begin
      back_m <= {in_level, irq_status, rst_flag};
      back_s <= back_m;
    end
  end

  // bit and byte framing, restarted by start and stop
  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state   <= ST_ADDR;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
    end else begin
      shift <= rx_byte;
      case (state)
        ST_ADDR: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == LAST_DATA_BIT) begin
            bit_cnt <= 4'h0;
            if (shift[6:0] == own_addr)
              state <= ST_AACK;
            else
              state <= ST_IDLE;
          end
        end
        ST_AACK: begin
          bit_cnt <= 4'h0;
          state   <= shift[0] ? ST_RD : ST_CMD;
        end
        ST_CMD, ST_WR: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == LAST_DATA_BIT) begin
            bit_cnt <= 4'h0;
            state   <= ST_WACK;
          end
        end
        ST_WACK: begin
          bit_cnt <= 4'h0;
          state   <= ST_WR;
        end
        ST_RD: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == LAST_DATA_BIT) begin
            bit_cnt <= 4'h0;
            state   <= ST_RACK;
          end
        end
        ST_RACK: begin
          bit_cnt <= 4'h0;
          state   <= sda_in ? ST_IDLE : ST_RD;
        end
        ST_IDLE: begin
          bit_cnt <= 4'h0;
        end
        default: begin
          state   <= ST_IDLE;
          bit_cnt <= 4'h0;
        end
      endcase
    end
  end

  // register file and pointer, untouched by start and stop
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      pointer               <= RST_POINTER;
      pointer_auto_step     <= 1'b0;
      pin_direction         <= RST_DIR;
      output_level          <= RST_OUT;
      output_hiz            <= RST_HIZ;
      input_compare_default <= RST_DFLT;
      pull_enable           <= RST_PULL_EN;
      pull_select           <= RST_PULL_SEL;
      irq_mask              <= RST_IRQ_MASK;
      sw_rst_tog            <= 1'b0;
      clr_irq_tog           <= 1'b0;
      clr_rst_tog           <= 1'b0;
    end else begin
      if (wr_done && state == ST_CMD) begin
        pointer           <= rx_byte[4:0];
        pointer_auto_step <= rx_byte[CMD_AUTO_BIT];
      end else if (wr_done) begin
        case (pointer)
          REG_ID_CTRL: begin
            if (rx_byte[SW_RESET_BIT]) begin
              pin_direction         <= RST_DIR;
              output_level          <= RST_OUT;
              output_hiz            <= RST_HIZ;
              input_compare_default <= RST_DFLT;
              pull_enable           <= RST_PULL_EN;
              pull_select           <= RST_PULL_SEL;
              irq_mask              <= RST_IRQ_MASK;
              sw_rst_tog            <= ~sw_rst_tog;
            end
          end
          REG_DIR:      pin_direction         <= rx_byte;
          REG_OUT:      output_level          <= rx_byte;
          REG_HIZ:      output_hiz            <= rx_byte;
          REG_DFLT:     input_compare_default <= rx_byte;
          REG_PULL_EN:  pull_enable           <= rx_byte;
          REG_PULL_SEL: pull_select           <= rx_byte;
          REG_IRQ_MASK: irq_mask              <= rx_byte;
          default: begin
          end
        endcase
        if (pointer_auto_step)
          pointer <= step_ptr(pointer);
      end
      if (rd_done && pointer == REG_IRQ_STAT)
        clr_irq_tog <= ~clr_irq_tog;
      if (rd_done && pointer == REG_ID_CTRL)
        clr_rst_tog <= ~clr_rst_tog;
      if (rd_more && pointer_auto_step)
        pointer <= step_ptr(pointer);
    end
  end

  // read value of the selected register
  always_comb begin
    case (pointer)
      REG_ID_CTRL:  rd_val = {MAKER_CODE, REVISION_CODE, back_s[0], 1'b0};
      REG_DIR:      rd_val = pin_direction;
      REG_OUT:      rd_val = output_level;
      REG_HIZ:      rd_val = output_hiz;
      REG_DFLT:     rd_val = input_compare_default;
      REG_PULL_EN:  rd_val = pull_enable;
      REG_PULL_SEL: rd_val = pull_select;
      REG_IN_LEVEL: rd_val = back_s[16:9];
      REG_IRQ_MASK: rd_val = irq_mask;
      REG_IRQ_STAT: rd_val = back_s[8:1];
      default:      rd_val = 8'h00;
    endcase
  end

  // sda drive changes while scl is low
  always_ff @(negedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe <= 1'b0;
      tx_sh  <= 8'h00;
    end else begin
      case (state)
        ST_AACK, ST_WACK: sda_oe <= 1'b1;
        ST_RD: begin
          if (bit_cnt == 4'h0) begin
            sda_oe <= ~rd_val[7];
            tx_sh  <= {rd_val[6:0], 1'b0};
          end else begin
            sda_oe <= ~tx_sh[7];
            tx_sh  <= {tx_sh[6:0], 1'b0};
          end
        end
        default: sda_oe <= 1'b0;
      endcase
    end
  end

  // ---------------- system domain (ref_clk) ----------------
  logic        scl_m, scl_s, sda_m, sda_s, sda_d;
  localparam logic [55:0] CFG_RST = {RST_DIR, RST_OUT, RST_HIZ, RST_DFLT,
                                     RST_PULL_EN, RST_PULL_SEL, RST_IRQ_MASK};
  logic [55:0] cfg_m, cfg_q, cfg_r, cfg_s;
  logic [7:0]  pin_m, pin_s;
  logic [2:0]  tog_m, tog_s, tog_d;
  logic [7:0]  dir_s, out_s, hiz_s, dflt_s, pen_s, psel_s, mask_s;
  logic [7:0]  armed, irq_set;
  logic        start_seen, stop_seen;
  logic        sw_evt, clr_irq_evt, clr_rst_evt;

  assign {dir_s, out_s, hiz_s, dflt_s, pen_s, psel_s, mask_s} = cfg_s;
  assign start_seen  = scl_s & sda_d & ~sda_s;
  assign stop_seen   = scl_s & ~sda_d & sda_s;
  assign sw_evt      = tog_s[2] ^ tog_d[2];
  assign clr_irq_evt = tog_s[1] ^ tog_d[1];
  assign clr_rst_evt = tog_s[0] ^ tog_d[0];
  assign irq_set     = ~dir_s & (pin_s ^ dflt_s) & armed;

  // pin and bus synchronisers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      pin_m <= 8'h00;
      pin_s <= 8'h00;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
      pin_m <= port_pin_in;
      pin_s <= pin_m;
    end
  end

  // start and stop restart the link logic
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      frame_clr <= 1'b0;
    else
      frame_clr <= start_seen | stop_seen;
  end

  // configuration and events from the link domain
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_m <= CFG_RST;
      cfg_q <= CFG_RST;
      cfg_r <= CFG_RST;
      cfg_s <= CFG_RST;
      tog_m <= 3'h0;
      tog_s <= 3'h0;
      tog_d <= 3'h0;
    end else begin
      cfg_m <= {pin_direction, output_level, output_hiz,
                input_compare_default, pull_enable, pull_select, irq_mask};
      cfg_q <= cfg_m;
      cfg_r <= cfg_q;
      // take the word only once it has settled, never a mix of two writes
      if (cfg_q == cfg_r)
        cfg_s <= cfg_r;
      tog_m <= {sw_rst_tog, clr_irq_tog, clr_rst_tog};
      tog_s <= tog_m;
      tog_d <= tog_s;
    end
  end

  // pin drivers and pull switches
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      high_side_driver <= 8'h00;
      low_side_driver  <= 8'h00;
      port_pin_out     <= 8'h00;
      port_pin_oe      <= 8'h00;
      input_buffer_en  <= 8'hFF;
      pullup_switch    <= 8'h00;
      pulldown_switch  <= 8'hFF;
    end else begin
      high_side_driver <= dir_s & ~hiz_s & out_s;
      low_side_driver  <= dir_s & ~hiz_s & ~out_s;
      port_pin_out     <= out_s;
      port_pin_oe      <= dir_s & ~hiz_s;
      input_buffer_en  <= ~dir_s;
      pullup_switch    <= pen_s & psel_s;
      pulldown_switch  <= pen_s & ~psel_s;
    end
  end

  // input level, change detection and interrupt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      in_level   <= 8'hFF;
      armed      <= 8'hFF;
      irq_status <= 8'h00;
      rst_flag   <= 1'b1;
      irq_oe     <= 1'b0;
    end else begin
      in_level <= dir_s | pin_s;
      armed    <= (armed & ~irq_set) | ~(pin_s ^ dflt_s);
      if (sw_evt)
        irq_status <= irq_set;
      else
        irq_status <= (irq_status & ~{8{clr_irq_evt}}) | irq_set;
      rst_flag <= sw_evt | (rst_flag & ~clr_rst_evt);
      irq_oe   <= rst_flag | (|(irq_status & ~mask_s & ~dir_s));
    end
  end

  // ---------------- checks ----------------
  property p_start_clear;
    @(posedge ref_clk) disable iff (!resetn)
    start_seen |=> frame_clr;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start not turned into link restart");

  property p_stop_clear;
    @(posedge ref_clk) disable iff (!resetn)
    (scl_s && !sda_d && sda_s) |=> frame_clr ##1 !frame_clr;
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stop not turned into one restart pulse");

  property p_addr_ack;
    @(posedge scl) disable iff (!link_rst_n)
    (state == ST_AACK || state == ST_WACK) |-> sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("acknowledge not driven low");

  property p_read_ack_release;
    @(posedge scl) disable iff (!link_rst_n)
    (state == ST_RACK) |-> !sda_oe;
  endproperty
  a_read_ack_release: assert property (p_read_ack_release)
    else $error("sda held during master acknowledge");

  property p_auto_step;
    @(posedge scl) disable iff (!resetn)
    (wr_done && state == ST_WR && pointer_auto_step)
      |=> pointer == step_ptr($past(pointer));
  endproperty
  a_auto_step: assert property (p_auto_step)
    else $error("pointer did not step after write");

  property p_fixed_ptr;
    @(posedge scl) disable iff (!resetn)
    (state == ST_WR && !pointer_auto_step) |=> $stable(pointer);
  endproperty
  a_fixed_ptr: assert property (p_fixed_ptr)
    else $error("pointer moved without auto step");

  property p_input_hiz;
    @(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> ((high_side_driver | low_side_driver) & ~$past(dir_s))
             == 8'h00;
  endproperty
  a_input_hiz: assert property (p_input_hiz)
    else $error("driver on for input pin");

  property p_output_drive;
    @(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> high_side_driver == $past(dir_s & ~hiz_s & out_s);
  endproperty
  a_output_drive: assert property (p_output_drive)
    else $error("high side driver wrong");

  property p_pulls;
    @(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> pulldown_switch == $past(pen_s & ~psel_s);
  endproperty
  a_pulls: assert property (p_pulls)
    else $error("pull-down switch wrong");

  property p_in_level_out;
    @(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> (in_level & $past(dir_s)) == $past(dir_s);
  endproperty
  a_in_level_out: assert property (p_in_level_out)
    else $error("output pin not read as 1");

  property p_status_clear;
    @(posedge ref_clk) disable iff (!resetn)
    (clr_irq_evt && !sw_evt) |=> (irq_status & ~$past(irq_set)) == 8'h00;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status not cleared by read");

  c_write_byte: cover property (@(posedge scl) disable iff (!link_rst_n)
    state == ST_WACK);
  c_read_nack: cover property (@(posedge scl) disable iff (!link_rst_n)
    state == ST_RACK && sda_in);
  c_sw_reset: cover property (@(posedge ref_clk) disable iff (!resetn)
    sw_evt);

endmodule : gpio_exp_regs

// [dv/i2c_master_model.sv]
// bus master model: start, stop, byte out and byte in
// assumes a pulled-up sda wire; scl idles high between frames
`timescale 1ns/1ps
module i2c_master_model (
  // bus
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // one scl pulse, sample mid-high; data set up over a system clock period
  task automatic pulse(output logic v);
    #70 scl = 1'b1;
    #40 v = sda;
    #40 scl = 1'b0;
    #10;
  endtask : pulse

  // start or repeated start, scl held long after the edge
  task automatic start_bit();
    sda_low = 1'b0;
    #70 scl = 1'b1;
    #250 sda_low = 1'b1;
    #250 scl = 1'b0;
    #40;
  endtask : start_bit

  task automatic stop_bit();
    sda_low = 1'b1;
    #70 scl = 1'b1;
    #250 sda_low = 1'b0;
    #250;
  endtask : stop_bit

  // data changes only while scl low
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(v);
    end
    sda_low = 1'b0;
    pulse(v);
    ack = ~v;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic v;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(v);
      b[i] = v;
    end
    sda_low = ~last;
    pulse(v);
    sda_low = 1'b0;
  endtask : get_byte
endmodule : i2c_master_model

// [dv/gpio_exp_regs_test.sv]
// self-checking bench of the gpio expander target
// assumes the master model drives scl and pulls the shared sda low
`timescale 1ns/1ps
module gpio_exp_regs_test;
  import gpio_exp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn;
  logic       addr_strap;
  logic [7:0] port_pin_in;
  logic       scl, sda_low, sda_out, sda_oe, irq_out, irq_oe;
  logic [7:0] port_pin_out, port_pin_oe, input_buffer_en;
  logic [7:0] high_side_driver, low_side_driver;
  logic [7:0] pullup_switch, pulldown_switch;
  wire        sda = ~sda_low & ~(sda_oe & ~sda_out);
  int         n_fail = 0;
  int         n_compared = 0;
  logic [6:0] dev;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [4:0] ptrs [10] = '{REG_ID_CTRL, REG_DIR, REG_OUT, REG_HIZ,
    REG_DFLT, REG_PULL_EN, REG_PULL_SEL, REG_IRQ_MASK, REG_IRQ_STAT, 5'h02};
  logic [7:0] exps [10] = '{{MAKER_CODE, REVISION_CODE, 2'b10}, RST_DIR,
    RST_OUT, RST_HIZ, RST_DFLT, RST_PULL_EN, RST_PULL_SEL, RST_IRQ_MASK,
    8'h00, 8'h00};
  logic [7:0] auto_exp [9] = '{8'hF0, 8'hA0, 8'h00, 8'h00, 8'h0F, 8'h0C,
    8'hF0, 8'h00, 8'h00};

  always #25 ref_clk = ~ref_clk;

  gpio_exp_regs u_gpio_exp_regs (
    .ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
    .irq_out(irq_out), .irq_oe(irq_oe), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .high_side_driver(high_side_driver), .low_side_driver(low_side_driver),
    .pullup_switch(pullup_switch), .pulldown_switch(pulldown_switch),
    .input_buffer_en(input_buffer_en)
  );

  i2c_master_model u_i2c_master_model (
    .scl(scl), .sda_low(sda_low), .sda(sda)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    u_i2c_master_model.put_byte(b, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask : send

  task automatic wr_regs(input logic [7:0] cmd);
    u_i2c_master_model.start_bit();
    send({dev, 1'b0}, 1'b1);
    send(cmd, 1'b1);
    foreach (wq[i]) send(wq[i], 1'b1);
    u_i2c_master_model.stop_bit();
  endtask : wr_regs

  task automatic rd_regs(input logic [7:0] cmd, input int n,
                         input bit ptr_wr);
    logic [7:0] b;
    rq.delete();
    u_i2c_master_model.start_bit();
    if (ptr_wr) begin
      send({dev, 1'b0}, 1'b1);
      send(cmd, 1'b1);
      u_i2c_master_model.start_bit();
    end
    send({dev, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_i2c_master_model.get_byte(i == n - 1, b);
      rq.push_back(b);
    end
    u_i2c_master_model.stop_bit();
  endtask : rd_regs

  task automatic rd_chk(input logic [4:0] ptr, input logic [7:0] exp);
    rd_regs({3'b000, ptr}, 1, 1'b1);
    check(rq[0], exp);
  endtask : rd_chk

  task automatic probe(input logic exp_ack);
    u_i2c_master_model.start_bit();
    send({dev, 1'b0}, exp_ack);
    u_i2c_master_model.stop_bit();
  endtask : probe

  task automatic set_pin(input logic [7:0] v);
    @(negedge ref_clk);
    port_pin_in = v;
  endtask : set_pin

  task automatic wait_irq(input logic v);
    for (int k = 0; k < 400 && irq_oe !== v; k++)
      @(negedge ref_clk);
    if (irq_oe !== v) begin
      n_fail++;
      final_report();
    end
    check({7'h00, irq_oe}, {7'h00, v});
  endtask : wait_irq

  initial begin
    resetn      = 1'b0;
    addr_strap  = 1'b0;
    port_pin_in = 8'h00;
    dev         = ADDR_STRAP_LO;
    repeat (16) @(negedge ref_clk);
    check(pulldown_switch, 8'hFF);
    check(pullup_switch, 8'h00);
    check(high_side_driver | low_side_driver, 8'h00);
    check(input_buffer_en, 8'hFF);
    check({6'h00, sda_out, irq_out}, 8'h00);
    resetn = 1'b1;
    wait_irq(1'b1);
    foreach (ptrs[i]) rd_chk(ptrs[i], exps[i]);
    wait_irq(1'b0);
    set_pin(8'h01);
    wait_irq(1'b1);
    rd_chk(REG_IRQ_STAT, 8'h01);
    wait_irq(1'b0);
    set_pin(8'h00);
    wq = '{8'hF0, 8'hA0, 8'h00, 8'h00};
    wr_regs(8'h83);
    @(negedge ref_clk);
    check(port_pin_oe, 8'hF0);
    check(port_pin_out, 8'hA0);
    check(high_side_driver, 8'hA0);
    check(low_side_driver, 8'h50);
    check(input_buffer_en, 8'h0F);
    wq = '{8'h0F, 8'h0C, 8'hAA, 8'h00};
    wr_regs(8'h8B);
    @(negedge ref_clk);
    check(pullup_switch, 8'h0C);
    check(pulldown_switch, 8'h03);
    rd_regs(8'h83, 9, 1'b1);
    foreach (rq[i]) check(rq[i], auto_exp[i]);
    wq = '{8'h11, 8'h22};
    wr_regs({3'b000, REG_OUT});
    rd_regs({3'b000, REG_OUT}, 2, 1'b1);
    check(rq[0], 8'h22);
    check(rq[1], 8'h22);
    check(high_side_driver, 8'h20);
    rd_regs(8'h00, 1, 1'b0);
    check(rq[0], 8'h22);
    rd_chk(REG_DIR, 8'hF0);
    set_pin(8'h05);
    rd_chk(REG_IN_LEVEL, 8'hF5);
    set_pin(8'h00);
    wq = '{8'h01};
    wr_regs({3'b000, REG_ID_CTRL});
    wait_irq(1'b1);
    rd_chk(REG_DIR, RST_DIR);
    wq = '{};
    wr_regs({3'b000, REG_ID_CTRL});
    rd_regs(8'h00, 1, 1'b0);
    check(rq[0], exps[0]);
    wq = '{8'h3C};
    wr_regs({3'b000, REG_DIR});
    rd_chk(REG_DIR, 8'h3C);
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    wait_irq(1'b1);
    rd_chk(REG_DIR, RST_DIR);
    dev = ADDR_STRAP_HI;
    probe(1'b0);
    @(negedge ref_clk);
    addr_strap = 1'b1;
    probe(1'b1);
    dev = ADDR_STRAP_LO;
    probe(1'b0);
    final_report();
  end
endmodule : gpio_exp_regs_test
